// File: exec_timing_pkg.sv
// Purpose: shared constants for the table access and cycle timing block
// Assumes: 20 MHz clock, four quarter phases per instruction cycle
// Notes: register offsets are byte addresses on a 32-bit AXI4-Lite bus
package exec_timing_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_OPERAND = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_RESULT = 8'h0c;
	localparam logic [7:0] OFS_TPTR = 8'h10;
	localparam logic [7:0] OFS_TLATCH = 8'h14;
	localparam logic [7:0] OFS_PCH = 8'h18;
	localparam logic [7:0] OFS_PC = 8'h1c;
	localparam logic [7:0] OFS_WREG = 8'h20;

	// status field positions
	localparam int ST_BUSY = 0;
	localparam int ST_PROG = 1;
	localparam int ST_CYC_LO = 2;
	localparam int ST_SKIP = 4;
	localparam int ST_WREG_WR = 5;
	localparam int ST_FILE_WR = 6;

	// ----------------------------------------------------------------
	// timing and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] Q_LAST = 2'h3;
	localparam logic [3:0] CLK_PER_CYC = 4'h4;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] TPTR_RESET = 16'h0000;
	localparam logic [15:0] TLATCH_RESET = 16'h0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// special file addresses
	localparam logic [7:0] WREG_ADDR = 8'h0a;
	localparam logic [7:0] PCL_ADDR = 8'h02;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// instruction classes
	typedef enum logic [3:0] {
		op_other, op_xorwf, op_tstfsz, op_btfsc, op_btfss, op_long_call,
		op_call_goto, op_ret, op_retlw, op_table_write, op_table_read
	} op_kind_t;

endpackage : exec_timing_pkg

// File: pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for a pin
// Assumes: input is asynchronous to i_clk
// Notes: output changes only once stages two and three agree
`timescale 1ns/10ps
module pin_sync (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// pin and filtered level
	input wire logic i_pin,
	output logic o_level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// stage one feeds only stage two
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			o_level <= 1'b0;
		end else if (i_ce) begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				o_level <= s3_q; // glitch of one sample never counts
			end
		end
	end
endmodule : pin_sync

// File: exec_timing.sv
// Purpose: instruction timing, destination select and table access engine
// Assumes: program memory answers reads in the same clock domain
// Notes: one instruction at a time, started by a write to the instruction register
//
// How it works
// - store-select one writes file only, unless the file named is the working register; zero writes both working register and file.
// - long call loads pc high byte from the pch register and low byte from literal.
// - internal table write keeps programming until an interrupt event ends it.
// - table write to external memory lasts exactly two instruction cycles.
// - skip or test takes two cycles when true, one otherwise.
// - transfers and table ops take two cycles; table read to pc low takes three.
// - a taken skip discards the prefetched instruction and runs a no-operation.
`timescale 1ns/10ps
module exec_timing
	import exec_timing_pkg::*;
#(
	parameter logic [15:0] INT_MEM_TOP = 16'h3fff
) (
	// clock, enable, reset
	input wire logic i_clk,
	input wire logic i_ce,
	input wire logic i_reset_n,
	// interrupt event pin
	input wire logic i_irq_event,
	// program memory
	output logic [15:0] o_pm_addr,
	output logic [15:0] o_pm_wdata,
	output logic o_pm_we,
	output logic o_pm_rd,
	output logic o_pm_prog,
	input wire logic [15:0] i_pm_rdata,
	// pipeline flush for skipped fetch
	output logic o_flush,
	output logic o_busy,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef enum logic [1:0] {st_idle, st_exec, st_prog} state_t;

	// ----------------------------------------------------------------
	// reset release and interrupt pin
	// ----------------------------------------------------------------
	logic rst_a_q, rst_n;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_a_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_a_q <= 1'b1;
			rst_n <= rst_a_q;
		end
	end

	logic irq_lvl, irq_old_q, irq_evt;
	pin_sync u_irq_sync (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_ce(i_ce),
		.i_pin(i_irq_event),
		.o_level(irq_lvl)
	);
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) irq_old_q <= 1'b0;
		else if (i_ce) irq_old_q <= irq_lvl;
	end
	assign irq_evt = irq_lvl & ~irq_old_q;

	// ----------------------------------------------------------------
	// axi4-lite write and read channels
	// ----------------------------------------------------------------
	logic aw_full_q, w_full_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_fire, busy_w, wr_err;
	state_t state_q;

	assign s_axi_awready = ~aw_full_q;
	assign s_axi_wready = ~w_full_q;
	assign wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid;
	assign busy_w = (state_q != st_idle);
	// registers owned by the engine refuse writes while it runs
	assign wr_err = !(aw_addr_q inside {OFS_INSTR, OFS_OPERAND, OFS_TPTR, OFS_TLATCH,
		OFS_PCH, OFS_WREG}) || (busy_w && aw_addr_q != OFS_OPERAND);

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (i_ce) begin
			if (s_axi_awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// byte-lane merge of a write into an existing value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		return (old & ~m) | (d & m);
	endfunction : merge

	logic wr_ok;
	assign wr_ok = wr_fire & ~wr_err;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic [15:0] instr_q;
	logic [7:0] operand_q, wreg_q, pch_q, result_q;
	logic [15:0] pc_q, tptr_q, tlatch_q;
	op_kind_t kind;
	logic cond_true;
	logic [1:0] base_cyc;
	logic [15:0] new_instr;

	// merge first, then cut: a function result cannot be part-selected directly
	logic [31:0] instr_mrg, operand_mrg, pch_mrg, wreg_mrg, tptr_mrg, tlatch_mrg;
	assign instr_mrg = merge({16'h0000, instr_q}, w_data_q, w_strb_q);
	assign operand_mrg = merge({24'h0, operand_q}, w_data_q, w_strb_q);
	assign pch_mrg = merge({24'h0, pch_q}, w_data_q, w_strb_q);
	assign wreg_mrg = merge({24'h0, wreg_q}, w_data_q, w_strb_q);
	assign tptr_mrg = merge({16'h0, tptr_q}, w_data_q, w_strb_q);
	assign tlatch_mrg = merge({16'h0, tlatch_q}, w_data_q, w_strb_q);
	assign new_instr = instr_mrg[15:0];

	always_comb begin
		kind = op_other;
		if (instr_q[15:9] == 7'b0000_110) kind = op_xorwf;
		else if (instr_q[15:8] == 8'h33) kind = op_tstfsz;
		else if (instr_q[15:11] == 5'b1001_1) kind = op_btfsc;
		else if (instr_q[15:11] == 5'b1001_0) kind = op_btfss;
		else if (instr_q[15:8] == 8'hb7) kind = op_long_call;
		else if (instr_q[15:8] == 8'hb6) kind = op_retlw;
		else if (instr_q[15:14] == 2'b11) kind = op_call_goto;
		else if (instr_q == 16'h0002 || instr_q == 16'h0005) kind = op_ret;
		else if (instr_q[15:10] == 6'b1010_11) kind = op_table_write;
		else if (instr_q[15:10] == 6'b1010_10) kind = op_table_read;
	end

	// skip conditions test the file operand
	always_comb begin
		case (kind)
			op_tstfsz: cond_true = (operand_q == 8'h00);
			op_btfsc: cond_true = ~operand_q[instr_q[10:8]];
			op_btfss: cond_true = operand_q[instr_q[10:8]];
			default: cond_true = 1'b0;
		endcase
	end

	logic ext_target;
	assign ext_target = (tptr_q > INT_MEM_TOP);

	always_comb begin
		case (kind)
			op_tstfsz, op_btfsc, op_btfss: base_cyc = cond_true ? 2'd2 : 2'd1;
			op_long_call, op_call_goto, op_ret, op_retlw, op_table_write: base_cyc = 2'd2;
			op_table_read: base_cyc = (instr_q[7:0] == PCL_ADDR) ? 2'd3 : 2'd2;
			default: base_cyc = 2'd1;
		endcase
	end

	// ----------------------------------------------------------------
	// sequencer: quarter phases and instruction cycles
	// ----------------------------------------------------------------
	logic pending_q, q4, last_cyc, start, finish, first_q4;
	logic [1:0] q_q, cyc_left_q, cyc_total_q;

	assign q4 = (q_q == Q_LAST);
	assign last_cyc = (cyc_left_q == 2'd0);
	assign start = (state_q == st_idle) & pending_q;
	assign first_q4 = (state_q == st_exec) & q4 & (cyc_left_q == cyc_total_q - 2'd1);
	assign finish = ((state_q == st_exec) & q4 & last_cyc & ~(kind == op_table_write & ~ext_target))
		| ((state_q == st_prog) & irq_evt);
	assign o_busy = busy_w | pending_q;

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= st_idle;
			q_q <= 2'd0;
			cyc_left_q <= 2'd0;
			cyc_total_q <= 2'd1;
			pending_q <= 1'b0;
		end else if (i_ce) begin
			if (wr_ok && aw_addr_q == OFS_INSTR) pending_q <= 1'b1;
			case (state_q)
				st_idle: if (pending_q) begin
					pending_q <= 1'b0;
					state_q <= st_exec;
					q_q <= 2'd0;
					cyc_left_q <= base_cyc - 2'd1;
					cyc_total_q <= base_cyc;
				end
				st_exec: begin
					q_q <= q_q + 2'd1;
					if (q4 && !last_cyc) cyc_left_q <= cyc_left_q - 2'd1;
					// internal programming outlasts the nominal cycles
					if (q4 && last_cyc) state_q <= finish ? st_idle : st_prog;
				end
				st_prog: if (irq_evt) state_q <= st_idle;
				default: state_q <= st_idle;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// datapath: destinations, program counter, table registers
	// ----------------------------------------------------------------
	logic skipped_q, wreg_wr_q, file_wr_q;
	logic [7:0] file_addr_q;
	logic [7:0] xor_res;
	assign xor_res = wreg_q ^ operand_q;

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			instr_q <= 16'h0000;
			operand_q <= BYTE_RESET;
			wreg_q <= BYTE_RESET;
			pch_q <= BYTE_RESET;
			result_q <= BYTE_RESET;
			file_addr_q <= BYTE_RESET;
			pc_q <= PC_RESET;
			skipped_q <= 1'b0;
			wreg_wr_q <= 1'b0;
			file_wr_q <= 1'b0;
		end else if (i_ce) begin
			if (wr_ok) begin
				case (aw_addr_q)
					OFS_INSTR: instr_q <= new_instr;
					OFS_OPERAND: operand_q <= operand_mrg[7:0];
					OFS_PCH: pch_q <= pch_mrg[7:0];
					OFS_WREG: wreg_q <= wreg_mrg[7:0];
					default: ;
				endcase
			end
			if (start) begin
				skipped_q <= 1'b0;
				wreg_wr_q <= 1'b0;
				file_wr_q <= 1'b0;
				file_addr_q <= instr_q[7:0];
			end
			if (first_q4) begin
				case (kind)
					op_xorwf: begin
						result_q <= xor_res;
						file_wr_q <= 1'b1;
						// naming the working register as file updates it alone
						if (!instr_q[8] || instr_q[7:0] == WREG_ADDR) begin
							wreg_q <= xor_res;
							wreg_wr_q <= 1'b1;
						end
					end
					op_retlw: begin
						wreg_q <= instr_q[7:0];
						wreg_wr_q <= 1'b1;
					end
					op_long_call: pc_q <= {pch_q, instr_q[7:0]};
					op_call_goto: pc_q <= {pc_q[15:13], instr_q[12:0]};
					op_table_read: begin
						result_q <= instr_q[9] ? tlatch_q[15:8] : tlatch_q[7:0];
						file_wr_q <= 1'b1;
						if (instr_q[7:0] == PCL_ADDR) begin
							pc_q <= {pch_q, instr_q[9] ? tlatch_q[15:8] : tlatch_q[7:0]};
						end
					end
					default: if (cond_true) skipped_q <= 1'b1;
				endcase
			end
			if (finish && !(kind inside {op_long_call, op_call_goto, op_table_read})) begin
				pc_q <= pc_q + (skipped_q ? 16'd2 : 16'd1);
			end
		end
	end

	// flush strobe and table engine
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_flush <= 1'b0;
			o_pm_we <= 1'b0;
			o_pm_rd <= 1'b0;
			o_pm_prog <= 1'b0;
			o_pm_addr <= TPTR_RESET;
			o_pm_wdata <= TLATCH_RESET;
			tptr_q <= TPTR_RESET;
			tlatch_q <= TLATCH_RESET;
		end else if (i_ce) begin
			o_flush <= first_q4 && cond_true;
			o_pm_we <= 1'b0;
			o_pm_rd <= 1'b0;
			if (wr_ok && aw_addr_q == OFS_TPTR) begin
				tptr_q <= tptr_mrg[15:0];
			end
			if (wr_ok && aw_addr_q == OFS_TLATCH) begin
				tlatch_q <= tlatch_mrg[15:0];
			end
			if (first_q4 && kind == op_table_write) begin
				if (instr_q[9]) tlatch_q[15:8] <= operand_q;
				else tlatch_q[7:0] <= operand_q;
			end
			// a read puts the pointer out a cycle early so memory data settle by the last q4
			if (first_q4 && kind == op_table_read) o_pm_addr <= tptr_q;
			// second cycle puts the latch and pointer on the memory bus
			if (state_q == st_exec && q4 && last_cyc && kind == op_table_write) begin
				o_pm_addr <= tptr_q;
				o_pm_wdata <= tlatch_q;
				if (ext_target) begin
					o_pm_we <= 1'b1;
					if (instr_q[8]) tptr_q <= tptr_q + 16'd1;
				end else begin
					o_pm_prog <= 1'b1;
				end
			end
			if (state_q == st_prog && irq_evt) begin
				o_pm_prog <= 1'b0;
				if (instr_q[8]) tptr_q <= tptr_q + 16'd1;
			end
			if (state_q == st_exec && q4 && last_cyc && kind == op_table_read) begin
				o_pm_addr <= tptr_q;
				o_pm_rd <= 1'b1;
				tlatch_q <= i_pm_rdata;
				if (instr_q[8]) tptr_q <= tptr_q + 16'd1;
			end
		end
	end

	// read channel: data always from a register
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (i_ce) begin
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				case (s_axi_araddr)
					OFS_INSTR: s_axi_rdata <= {16'h0, instr_q};
					OFS_OPERAND: s_axi_rdata <= {24'h0, operand_q};
					OFS_STATUS: s_axi_rdata <= {25'h0, file_wr_q, wreg_wr_q, skipped_q,
						cyc_total_q, state_q == st_prog, o_busy};
					OFS_RESULT: s_axi_rdata <= {16'h0, file_addr_q, result_q};
					OFS_TPTR: s_axi_rdata <= {16'h0, tptr_q};
					OFS_TLATCH: s_axi_rdata <= {16'h0, tlatch_q};
					OFS_PCH: s_axi_rdata <= {24'h0, pch_q};
					OFS_PC: s_axi_rdata <= {16'h0, pc_q};
					OFS_WREG: s_axi_rdata <= {24'h0, wreg_q};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	assign s_axi_arready = ~s_axi_rvalid;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk iff i_ce); endclocking
	default disable iff (!rst_n);

	logic [3:0] clk_cnt_q;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) clk_cnt_q <= 4'h0;
		else if (i_ce) clk_cnt_q <= start ? 4'h1 : (busy_w ? clk_cnt_q + 4'h1 : clk_cnt_q);
	end

	a_dest_file_only: assert property (first_q4 && kind == op_xorwf && instr_q[8]
		&& instr_q[7:0] != WREG_ADDR |=> $stable(wreg_q)) else $error("file-only wrote wreg");
	a_dest_both: assert property (first_q4 && kind == op_xorwf && !instr_q[8]
		|=> wreg_q == result_q && wreg_wr_q) else $error("both destinations not written");
	a_long_call_pc: assert property (first_q4 && kind == op_long_call
		|=> pc_q == {$past(pch_q), $past(instr_q[7:0])}) else $error("long call pc wrong");
	a_prog_hold: assert property (state_q == st_prog && !irq_evt
		|=> state_q == st_prog && o_pm_prog) else $error("programming ended early");
	a_ext_write_len: assert property (o_pm_we |-> $past(clk_cnt_q) == 4'd8)
		else $error("external table write not two cycles");
	a_skip_len: assert property (finish && state_q == st_exec && kind inside {op_tstfsz,
		op_btfsc, op_btfss} |-> clk_cnt_q == (skipped_q ? 4'd8 : 4'd4)) else $error("skip timing");
	a_read_pcl_len: assert property (finish && kind == op_table_read
		&& instr_q[7:0] == PCL_ADDR |-> clk_cnt_q == 4'd12) else $error("table read to pc low");
	a_flush_nop: assert property (o_flush |-> state_q == st_exec && !cyc_left_q[1]
		##3 finish) else $error("flush without nop cycle");
	a_ptr_step: assert property (o_pm_we |-> tptr_q == o_pm_addr + {15'h0, instr_q[8]})
		else $error("pointer step wrong");

	c_skip_taken: cover property (o_flush);
	c_ext_write: cover property (o_pm_we);
	c_prog_end: cover property (state_q == st_prog ##1 state_q == st_idle);
	c_read_pcl: cover property (finish && kind == op_table_read && instr_q[7:0] == PCL_ADDR);

endmodule : exec_timing

// File: prog_mem_model.sv
// Purpose: program memory seen by the table access engine
// Assumes: reads answer in the same clock domain, writes are single strobes
// Notes: read data is a fixed pattern of the address so the bench can predict it
`timescale 1ns/10ps
module prog_mem_model (
	// clock
	input wire logic i_clk,
	// engine side
	input wire logic [15:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_we,
	input wire logic i_rd,
	input wire logic i_prog,
	// read data back to the engine
	output logic [15:0] o_rdata
);
	// ----------------------------------------------------------------
	// storage and monitors
	// ----------------------------------------------------------------
	int n_wr = 0;
	int n_prog = 0;
	int n_rd = 0;
	logic [15:0] last_addr = 16'h0000;
	logic [15:0] last_data = 16'h0000;

	// pattern mixes both address bytes so a wrong pointer shows up
	assign o_rdata = {i_addr[7:0], ~i_addr[15:8]};

	// external writes are recorded, internal programming counted per clock
	always @(posedge i_clk) begin
		if (i_we) begin
			n_wr <= n_wr + 1;
			last_addr <= i_addr;
			last_data <= i_wdata;
		end
		if (i_rd) begin
			n_rd <= n_rd + 1;
		end
		if (i_prog) begin
			n_prog <= n_prog + 1;
		end
	end
endmodule : prog_mem_model

// File: table_access_and_cycle_timing_bench.sv
// Purpose: register level tests of instruction timing and table access
// Assumes: 20 MHz clock, internal memory top at its default
// Notes: every instruction is started and polled over the register bus
`timescale 1ns/10ps
module table_access_and_cycle_timing_bench;
	import exec_timing_pkg::*;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_irq_event = 1'b0;
	logic ce = 1'b1;
	logic [15:0] pm_addr, pm_wdata, pm_rdata;
	logic pm_we, pm_rd, pm_prog, flush, busy;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	int n_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int busy_clks = 0;
	int flushes = 0;
	logic [31:0] st, v;

	exec_timing u_exec_timing (.i_clk(i_clk), .i_ce(ce), .i_reset_n(i_reset_n),
		.i_irq_event(i_irq_event), .o_pm_addr(pm_addr), .o_pm_wdata(pm_wdata),
		.o_pm_we(pm_we), .o_pm_rd(pm_rd), .o_pm_prog(pm_prog), .i_pm_rdata(pm_rdata),
		.o_flush(flush), .o_busy(busy), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	prog_mem_model u_prog_mem_model (.i_clk(i_clk), .i_addr(pm_addr), .i_wdata(pm_wdata),
		.i_we(pm_we), .i_rd(pm_rd), .i_prog(pm_prog), .o_rdata(pm_rdata));

	// ----------------------------------------------------------------
	// clock, monitors and hang guard
	// ----------------------------------------------------------------
	initial begin
		forever #25 i_clk = ~i_clk;
	end

	// whole run needs a few hundred clocks, so the ceiling leaves ample slack
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (busy === 1'b1) busy_clks <= busy_clks + 1;
		if (flush === 1'b1) flushes <= flushes + 1;
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			results();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			n_errors++;
		end
	endtask : chk

	// address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge i_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge i_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge i_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge i_clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		rready <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask : rd

	task automatic wait_idle();
		do rd(OFS_STATUS, st, RESP_OKAY);
		while (st[ST_BUSY] !== 1'b0);
	endtask : wait_idle

	// start one instruction and check its length in instruction cycles
	task automatic run(input logic [15:0] ins, input logic [7:0] f, input int n, input logic sk);
		int b0;
		int f0;
		wr(OFS_OPERAND, {24'h0, f}, RESP_OKAY);
		// monitors keep running totals; only the difference belongs to this run
		b0 = busy_clks;
		f0 = flushes;
		wr(OFS_INSTR, {16'h0, ins}, RESP_OKAY);
		wait_idle();
		chk("cycle count", n, {30'h0, st[ST_CYC_LO +: 2]});
		chk("skipped", {31'h0, sk}, {31'h0, st[ST_SKIP]});
		chk("flushes", {31'h0, sk}, flushes - f0);
		// pending start adds one clock ahead of execution; the check allows up to four
		chk("busy length", 1, (busy_clks - b0 >= 4 * n && busy_clks - b0 <= 4 * n + 4));
	endtask : run

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	logic [15:0] xfer [5] = '{16'he123, 16'hc045, 16'h0002, 16'hb611, 16'hb73c};
	logic [15:0] skp_op [4] = '{16'h3340, 16'h3340, 16'h9340, 16'h9b40};
	logic [7:0] skp_f [4] = '{8'h00, 8'h05, 8'h08, 8'h08};
	logic skp_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

	initial begin
		repeat (2) @(posedge i_clk);
		i_reset_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		rd(OFS_PC, v, RESP_OKAY);
		chk("pc reset", {16'h0, PC_RESET}, v);
		rd(8'h3c, v, RESP_SLVERR);
		chk("unmapped data", 32'h0, v);
		// store select one leaves the working register alone
		wr(OFS_WREG, 32'h0f, RESP_OKAY);
		run(16'h0d40, 8'hf0, 1, 1'b0);
		chk("file only wreg flag", 32'h0, {31'h0, st[ST_WREG_WR]});
		chk("file only file flag", 32'h1, {31'h0, st[ST_FILE_WR]});
		rd(OFS_RESULT, v, RESP_OKAY);
		chk("xor result", 32'hff, {24'h0, v[7:0]});
		rd(OFS_WREG, v, RESP_OKAY);
		chk("wreg kept", 32'h0f, v);
		run(16'h0c40, 8'hf0, 1, 1'b0);
		chk("both wreg flag", 32'h1, {31'h0, st[ST_WREG_WR]});
		rd(OFS_WREG, v, RESP_OKAY);
		chk("wreg written", 32'hff, v);
		// the working register named as the file operand
		run(16'h0d0a, 8'h0f, 1, 1'b0);
		rd(OFS_RESULT, v, RESP_OKAY);
		chk("file address", {24'h0, WREG_ADDR}, {24'h0, v[15:8]});
		rd(OFS_WREG, v, RESP_OKAY);
		chk("wreg alone", 32'hf0, v);
		// every skip kind: zero test true and false, bit-set skip true, bit-clear skip false
		for (int k = 0; k < 4; k++) begin
			run(skp_op[k], skp_f[k], skp_exp[k] ? 2 : 1, skp_exp[k]);
		end
		// control transfers, long call last
		wr(OFS_PCH, 32'h5a, RESP_OKAY);
		for (int k = 0; k < 5; k++) begin
			run(xfer[k], 8'h00, 2, 1'b0);
		end
		rd(OFS_PC, v, RESP_OKAY);
		chk("long call pc", 32'h5a3c, v);
		// table read into a plain file, then into the pc low byte
		wr(OFS_TPTR, 32'h0123, RESP_OKAY);
		wr(OFS_TLATCH, 32'haa55, RESP_OKAY);
		run(16'hab30, 8'h00, 2, 1'b0);
		rd(OFS_RESULT, v, RESP_OKAY);
		chk("read high byte", 32'haa, {24'h0, v[7:0]});
		rd(OFS_TLATCH, v, RESP_OKAY);
		chk("latch from memory", 32'h23fe, v);
		rd(OFS_TPTR, v, RESP_OKAY);
		chk("pointer stepped", 32'h0124, v);
		run(16'ha802, 8'h00, 3, 1'b0);
		chk("mem reads", 2, u_prog_mem_model.n_rd);
		// external table write, high byte, pointer stepped
		wr(OFS_TPTR, 32'h4000, RESP_OKAY);
		wr(OFS_TLATCH, 32'h1234, RESP_OKAY);
		run(16'haf31, 8'ha5, 2, 1'b0);
		chk("ext writes", 1, u_prog_mem_model.n_wr);
		chk("ext addr", 32'h4000, {16'h0, u_prog_mem_model.last_addr});
		chk("ext data", 32'ha534, {16'h0, u_prog_mem_model.last_data});
		rd(OFS_TPTR, v, RESP_OKAY);
		chk("ext pointer", 32'h4001, v);
		// internal write runs until the interrupt event
		wr(OFS_TPTR, 32'h0010, RESP_OKAY);
		wr(OFS_OPERAND, 32'h77, RESP_OKAY);
		wr(OFS_INSTR, 32'had31, RESP_OKAY);
		repeat (40) @(posedge i_clk);
		chk("programming", 1, {31'h0, pm_prog});
		chk("still busy", 1, {31'h0, busy});
		wr(OFS_INSTR, 32'h0002, RESP_SLVERR);
		chk("int data", 32'ha577, {16'h0, pm_wdata});
		// with the clock enable low the event must not reach the engine
		ce <= 1'b0;
		i_irq_event <= 1'b1;
		repeat (10) @(posedge i_clk);
		chk("frozen prog", 1, {31'h0, pm_prog});
		ce <= 1'b1;
		wait_idle();
		i_irq_event <= 1'b0;
		chk("prog ended", 0, {31'h0, pm_prog});
		chk("no ext write", 1, u_prog_mem_model.n_wr);
		chk("prog clocks", 1, {31'h0, u_prog_mem_model.n_prog > 30});
		rd(OFS_TPTR, v, RESP_OKAY);
		chk("int pointer", 32'h0011, v);
		results();
	end
endmodule : table_access_and_cycle_timing_bench
